// File: design/hmhc_top.sv
// hmhc_top: homing sequencer and run-to-hold current timer.
// assumes synchronous inputs, reference inputs already resolved to active-high,
// and that the step generator follows the drive request every cycle.
`timescale 1ns/1ps
`default_nettype none

module hmhc_top
  import hmhc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
)
(
  input wire logic ref_clk, // 250 MHz clock
  input wire logic rst, // synchronous reset, high
  input wire logic ce, // clock enable, freezes state when low
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [15:0] reg_addr, // register address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic offset_start, // home-to-offset command pulse
  input wire logic [15:0] offset_type, // type for the offset command
  input wire logic encoder_enable_flag, // encoder fitted and enabled
  input wire logic index_mark, // encoder index mark active
  input wire logic offset_reached, // at the index offset position
  input wire logic home_switch, // home input, active level resolved
  input wire logic motion_busy, // other motion in progress
  input wire logic [15:0] settling_delay, // settling delay, ms
  input wire logic [7:0] run_current_level, // run current, percent
  input wire logic [7:0] hold_current_level, // hold current, percent, 0 = off
  output logic [15:0] reg_rdata, // read data
  output hmhc_err_s err, // error pulse and code
  output logic busy, // homing in progress
  output hmhc_drive_s drive, // axis drive request
  output logic [7:0] current_level, // winding current, percent
  output logic current_reduced // settling plus hold delay elapsed; hold current applied unless hold level is 0
);

  hmhc_state_s q;
  hmhc_state_s nxt_q;
  logic ref_hit;
  logic moving;
  logic [16:0] delay_sum;
  logic [16:0] ht_sum;
  logic start_ok;
  logic start_req;
  logic [15:0] start_type;
  hmhc_mode_e start_mode;

  //////////////////////////////////////////////////////////////////////////////
  // reference selection per homing mode
  always_comb
  begin
    case (q.mode)
      HMHC_TO_INDEX: ref_hit = index_mark;
      HMHC_TO_OFFSET: ref_hit = offset_reached;
      HMHC_TO_SWITCH: ref_hit = home_switch;
      default: ref_hit = 1'b0;
    endcase
  end

  // combined delay and proposed hold-delay sum, 17 bits to catch overflow
  assign delay_sum = {1'b0, settling_delay} + {1'b0, q.hold_delay};
  assign ht_sum = {1'b0, settling_delay} + {1'b0, reg_wdata};
  assign moving = q.busy | motion_busy;

  // one homing start per cycle; register commands take priority over the offset pulse
  always_comb
  begin
    start_req = 1'b0;
    start_type = reg_wdata;
    start_mode = HMHC_TO_INDEX;
    if (reg_wr && reg_addr == ADDR_HOME_INDEX)
    begin
      start_req = 1'b1;
    end
    else if (reg_wr && reg_addr == ADDR_HOME_SWITCH)
    begin
      start_req = 1'b1;
      start_mode = HMHC_TO_SWITCH;
    end
    else if (offset_start)
    begin
      start_req = 1'b1;
      start_type = offset_type;
      start_mode = HMHC_TO_OFFSET;
    end
    start_ok = start_type >= TYPE_MIN && start_type <= TYPE_MAX;
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    nxt_q = q;
    nxt_q.err.valid = 1'b0;
    // homing sequence
    case (q.phase)
      HMHC_SLEW:
      begin
        if (ref_hit)
        begin
          nxt_q.phase = HMHC_CREEP;
          nxt_q.drive.slew = 1'b0;
          nxt_q.drive.plus = q.htype == 3'd1 || q.htype == 3'd4;
        end
      end
      HMHC_CREEP:
      begin
        // stop the moment the reference clears
        if (!ref_hit)
        begin
          nxt_q.phase = HMHC_IDLE;
          nxt_q.drive = '0;
          nxt_q.busy = 1'b0;
        end
      end
      default: nxt_q.phase = HMHC_IDLE;
    endcase
    // a new command restarts the sequence even mid-homing
    if (start_req)
    begin
      if (!start_ok)
      begin
        nxt_q.err = '{valid: 1'b1, code: ERR_ILLEGAL_DATA};
      end
      else if (start_mode != HMHC_TO_SWITCH && !encoder_enable_flag)
      begin
        nxt_q.err = '{valid: 1'b1, code: ERR_NO_ENCODER};
      end
      else
      begin
        nxt_q.phase = HMHC_SLEW;
        nxt_q.mode = start_mode;
        nxt_q.htype = start_type[2:0];
        nxt_q.busy = 1'b1;
        nxt_q.drive.en = 1'b1;
        nxt_q.drive.slew = 1'b1;
        nxt_q.drive.plus = start_type[2:0] >= 3'd3;
        if (start_mode == HMHC_TO_INDEX)
          nxt_q.index_reg = reg_wdata;
        else if (start_mode == HMHC_TO_SWITCH)
          nxt_q.switch_reg = reg_wdata;
      end
    end
    // hold delay write, checked against the settling delay
    if (reg_wr && reg_addr == ADDR_HOLD_DELAY)
    begin
      if (ht_sum > DELAY_SUM_MAX)
        nxt_q.err = '{valid: 1'b1, code: ERR_ILLEGAL_DATA};
      else
        nxt_q.hold_delay = reg_wdata;
    end
    // register reads
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_HOME_INDEX: nxt_q.rdata = q.index_reg;
        ADDR_HOME_SWITCH: nxt_q.rdata = q.switch_reg;
        ADDR_HOLD_DELAY: nxt_q.rdata = q.hold_delay;
        default: nxt_q.rdata = '0;
      endcase
    end
    // run-to-hold timer; ms ticks counted while idle only
    if (moving || delay_sum == '0)
    begin
      nxt_q.tick_cnt = '0;
      nxt_q.ms_cnt = '0;
      nxt_q.reduced = 1'b0;
    end
    else if (!q.reduced)
    begin
      if (q.ms_cnt >= delay_sum)
        nxt_q.reduced = 1'b1;
      else if (q.tick_cnt == 18'(MS_CYCLES - 1))
      begin
        nxt_q.tick_cnt = '0;
        nxt_q.ms_cnt = q.ms_cnt + 17'd1;
      end
      else
        nxt_q.tick_cnt = q.tick_cnt + 18'd1;
    end
    // hold level zero keeps run current
    if (nxt_q.reduced && hold_current_level != '0)
      nxt_q.current = hold_current_level;
    else
      nxt_q.current = run_current_level;
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      q <= '0;
      q.hold_delay <= HOLD_DELAY_RST;
      q.current <= HOLD_LEVEL_DEF;
    end
    else if (ce)
      q <= nxt_q;
  end

  assign reg_rdata = q.rdata;
  assign err = q.err;
  assign busy = q.busy;
  assign drive = q.drive;
  assign current_level = q.current;
  assign current_reduced = q.reduced;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  slew_direction_a: assert property (q.phase == HMHC_SLEW |-> drive.en && drive.slew &&
    drive.plus == (q.htype >= 3'd3)) else $error("slew direction or speed wrong");
  creep_direction_a: assert property (q.phase == HMHC_CREEP |-> drive.en && !drive.slew &&
    drive.plus == (q.htype == 3'd1 || q.htype == 3'd4)) else $error("creep direction wrong");
  index_reverse_a: assert property (ce && !start_req && q.phase == HMHC_SLEW &&
    q.mode == HMHC_TO_INDEX && index_mark |=> q.phase == HMHC_CREEP) else $error("no creep");
  creep_stop_a: assert property (ce && !start_req && q.phase == HMHC_CREEP &&
    q.mode != HMHC_TO_SWITCH && !ref_hit |=> !drive.en && !busy) else $error("creep runs on");
  switch_stop_a: assert property (ce && !start_req && q.phase == HMHC_CREEP &&
    q.mode == HMHC_TO_SWITCH && !home_switch |=> !drive.en && !busy) else $error("switch stop");
  bad_type_a: assert property (ce && reg_wr && reg_addr == ADDR_HOME_SWITCH &&
    reg_wdata > TYPE_MAX |=> err.valid && err.code == ERR_ILLEGAL_DATA && !$rose(busy))
    else $error("bad type accepted");
  encoder_needed_a: assert property (ce && reg_wr && reg_addr == ADDR_HOME_INDEX &&
    start_ok && !encoder_enable_flag |=> err.valid && err.code == ERR_NO_ENCODER)
    else $error("index homing without encoder");
  hold_reject_a: assert property (ce && reg_wr && reg_addr == ADDR_HOLD_DELAY &&
    ht_sum > DELAY_SUM_MAX |=> err.code == ERR_ILLEGAL_DATA && $stable(q.hold_delay))
    else $error("oversized hold delay taken");
  no_reduce_a: assert property (ce && delay_sum == '0 |=> !current_reduced)
    else $error("current reduced with zero delays");
  motion_restore_a: assert property (ce && moving |=> !current_reduced &&
    current_level == $past(run_current_level)) else $error("run current not restored");
  early_drop_a: assert property ($rose(current_reduced) |-> q.ms_cnt >= $past(delay_sum))
    else $error("current dropped early");

  index_home_c: cover property (q.phase == HMHC_CREEP && q.mode == HMHC_TO_INDEX ##1
    q.phase == HMHC_IDLE);
  switch_home_c: cover property (q.mode == HMHC_TO_SWITCH && $fell(busy));
  hold_drop_c: cover property ($rose(current_reduced) && q.hold_delay == '0);

endmodule : hmhc_top

`default_nettype wire

// File: shared/hmhc_pkg.sv
// hmhc_pkg: constants, states and carriers for the homing and hold-current block.
// assumes one 250 MHz clock and a synchronous register port with 16-bit data.
// What this block does
// - an index-homing command slews at slew velocity until the index mark, then creeps in the direction its type sets.
// - index and index-offset homing stop creeping once the reference position is cleared.
// - switch homing slews until the home switch is active, creeps, and stops when it deactivates.
// - type 1 slews minus and creeps plus, 2 minus/minus, 3 plus/minus, 4 plus/plus.
// - only homing types one to four are accepted, with the same meaning for every homing command.
// - switch homing works without an encoder; index and offset homing need it enabled.
// - offset homing of type 3 seeks the offset moving plus and creeps off moving minus.
// - after motion ends, wait settling delay plus hold delay in ms, then drop to hold current.
// - a hold delay is accepted only while it plus the settling delay stays within 65535.
// - an oversized hold delay write is dropped and reports error 21.
// - with a zero hold delay the settling delay still applies before the current drops.
// - with both delays zero the current never drops and run current is kept.
// - the hold delay counts milliseconds and resets to 500.
// - hold level zero disables the reduction, else it is a percentage from 1 to 100, default 5.
package hmhc_pkg;

  // register addresses on the command port
  localparam logic [15:0] ADDR_HOME_INDEX = 16'h002a;
  localparam logic [15:0] ADDR_HOME_SWITCH = 16'h002b;
  localparam logic [15:0] ADDR_HOLD_DELAY = 16'h002c;

  // reset values and the delay-sum limit
  localparam logic [15:0] HOLD_DELAY_RST = 16'h01f4;
  localparam logic [7:0] HOLD_LEVEL_DEF = 8'h05;
  localparam logic [16:0] DELAY_SUM_MAX = 17'h0_ffff;

  // homing type range and error codes
  localparam logic [15:0] TYPE_MIN = 16'h0001;
  localparam logic [15:0] TYPE_MAX = 16'h0004;
  localparam logic [7:0] ERR_ILLEGAL_DATA = 8'h15;
  localparam logic [7:0] ERR_NO_ENCODER = 8'h40; // value arbitrary

  // millisecond timebase
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    HMHC_IDLE = 2'b00,
    HMHC_SLEW = 2'b01,
    HMHC_CREEP = 2'b10
  } hmhc_phase_e;

  typedef enum logic [1:0] {
    HMHC_TO_INDEX = 2'b00,
    HMHC_TO_OFFSET = 2'b01,
    HMHC_TO_SWITCH = 2'b10
  } hmhc_mode_e;

  // drive request toward the step generator
  typedef struct packed {
    logic en;   // axis moving
    logic plus; // 1 = plus direction
    logic slew; // 1 = slew velocity, 0 = creep velocity
  } hmhc_drive_s;

  // error report
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } hmhc_err_s;

  typedef struct packed {
    hmhc_phase_e phase;
    hmhc_mode_e mode;
    logic [2:0] htype;
    logic [15:0] index_reg;
    logic [15:0] switch_reg;
    logic [15:0] hold_delay;
    logic busy;
    hmhc_drive_s drive;
    hmhc_err_s err;
    logic [15:0] rdata;
    logic [17:0] tick_cnt;
    logic [16:0] ms_cnt;
    logic reduced;
    logic [7:0] current;
  } hmhc_state_s;

endpackage : hmhc_pkg

// File: tb/hmhc_motor.sv
// hmhc_motor: behavioural axis with one reference band for index, offset and switch.
// assumes the drive request is followed one step per clock; load presets the position.
`timescale 1ns/1ps
`default_nettype none

module hmhc_motor
  import hmhc_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic load, // preset position
  input wire logic signed [15:0] start_pos, // position to preset
  input wire hmhc_drive_s drive, // step request
  output logic index_mark, // index band
  output logic offset_reached, // offset band
  output logic home_switch // switch band, active high
);
  logic signed [15:0] pos;

  // one step per moving cycle; speed is not modelled, only direction
  always_ff @(posedge ref_clk)
    if (load)
      pos <= start_pos;
    else if (drive.en)
      pos <= drive.plus ? pos + 16'sh0001 : pos - 16'sh0001;

  ////////////////////////////////////////////////////////////////////////////////
  // narrow band, so creep in either direction clears it within a few steps
  assign index_mark = (pos >= 16'sh0000) && (pos < 16'sh0004);
  assign offset_reached = index_mark;
  assign home_switch = index_mark;
endmodule : hmhc_motor

`default_nettype wire

// File: tb/hmhc_top_bench.sv
// hmhc_top_bench: directed bench for homing and the hold-current timer.
// assumes hmhc_motor stands in for the axis; one millisecond is four clocks here.
`timescale 1ns/1ps
`default_nettype none

module hmhc_top_bench
  import hmhc_pkg::*;
;
  logic ref_clk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, offset_start = 0, load = 1;
  logic encoder_enable_flag = 1, motion_busy = 0, busy, current_reduced;
  logic index_mark, offset_reached, home_switch;
  logic [15:0] reg_addr = 0, reg_wdata = 0, offset_type = 0, settling_delay = 0, reg_rdata;
  logic signed [15:0] start_pos = 0;
  logic [7:0] run_current_level = 8'h40, hold_current_level = 8'h05, current_level;
  hmhc_err_s err;
  hmhc_drive_s drive;
  int n_fail = 0, samples_checked = 0;

  hmhc_top #(.MS_CYCLES(4)) hmhc_top_i (.ref_clk, .rst, .ce, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .offset_start, .offset_type, .encoder_enable_flag, .index_mark,
    .offset_reached, .home_switch, .motion_busy, .settling_delay, .run_current_level,
    .hold_current_level, .reg_rdata, .err, .busy, .drive, .current_level, .current_reduced);
  hmhc_motor hmhc_motor_i (.ref_clk, .load, .start_pos, .drive, .index_mark,
    .offset_reached, .home_switch);

  // 250 MHz
  initial
    forever #2 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask : chk

  // sample just after the edge so registered outputs have settled
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tk

  // one register access; returns just after the taking edge, while the one-cycle
  // error pulse still stands
  task automatic acc(input logic w, input logic [15:0] a, d);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask : acc

  // bounded wait on the drive request; a miss ends the run
  task automatic wt(input logic [2:0] want);
    for (int i = 0; i < 200 && drive !== want; i++)
      tk(1);
    chk("drive", drive, want);
    if (drive !== want)
      results();
  endtask : wt

  ////////////////////////////////////////////////////////////////////////////////
  // full homing run; address zero means the offset command
  task automatic home(input logic [15:0] a, t);
    logic sp;
    logic cp;
    sp = t > 16'h0002;
    cp = t == 16'h0001 || t == 16'h0004;
    @(posedge ref_clk);
    load <= 1'b1;
    start_pos <= sp ? 16'shfff6 : 16'sh000a;
    @(posedge ref_clk);
    load <= 1'b0;
    offset_start <= a == 16'h0000;
    offset_type <= t;
    if (a != 16'h0000)
      acc(1'b1, a, t);
    else
    begin
      @(posedge ref_clk);
      offset_start <= 1'b0;
      tk(1);
    end
    chk("busy", busy, 1'b1);
    chk("slew", drive, {1'b1, sp, 1'b1});
    wt({1'b1, cp, 1'b0});
    wt(3'b000);
    chk("idle", busy, 1'b0);
  endtask : home

  task automatic limit;
    @(posedge ref_clk);
    settling_delay <= 16'h0064;
    acc(1'b1, ADDR_HOLD_DELAY, 16'hff9c);
    chk("err", err, {1'b1, ERR_ILLEGAL_DATA});
    acc(1'b0, ADDR_HOLD_DELAY, 16'h0000);
    chk("kept", reg_rdata, HOLD_DELAY_RST);
    acc(1'b1, ADDR_HOLD_DELAY, 16'hff9b);
    chk("ok", err.valid, 1'b0);
    acc(1'b0, ADDR_HOLD_DELAY, 16'h0000);
    chk("max", reg_rdata, 16'hff9b);
  endtask : limit

  task automatic badtype;
    for (int v = 0; v < 6; v += 5)
    begin
      acc(1'b1, ADDR_HOME_SWITCH, v[15:0]);
      chk("err", err, {1'b1, ERR_ILLEGAL_DATA});
      chk("busy", busy, 1'b0);
    end
  endtask : badtype

  task automatic noenc;
    @(posedge ref_clk);
    encoder_enable_flag <= 1'b0;
    acc(1'b1, ADDR_HOME_INDEX, 16'h0001);
    chk("err", err, {1'b1, ERR_NO_ENCODER});
    home(ADDR_HOME_SWITCH, 16'h0002);
    acc(1'b0, ADDR_HOME_SWITCH, 16'h0000);
    chk("type", reg_rdata, 16'h0002);
    acc(1'b0, 16'h0030, 16'h0000);
    chk("unmapped", reg_rdata, 16'h0000);
    @(posedge ref_clk);
    encoder_enable_flag <= 1'b1;
  endtask : noenc

  // clock enable low: a write is not taken, so the last hold delay stays
  task automatic freeze;
    @(posedge ref_clk);
    ce <= 1'b0;
    acc(1'b1, ADDR_HOLD_DELAY, 16'h0007);
    @(posedge ref_clk);
    ce <= 1'b1;
    acc(1'b0, ADDR_HOLD_DELAY, 16'h0000);
    chk("frozen", reg_rdata, 16'h0001);
  endtask : freeze

  // motion pulse, then the current must hold at run until n clocks pass
  task automatic hold(input logic [15:0] st, ht, input logic [7:0] hl, ecur, input int n);
    @(posedge ref_clk);
    settling_delay <= st;
    hold_current_level <= hl;
    motion_busy <= 1'b1;
    acc(1'b1, ADDR_HOLD_DELAY, ht);
    chk("run", current_level, run_current_level);
    @(posedge ref_clk);
    motion_busy <= 1'b0;
    tk(n - 2);
    chk("early", current_level, run_current_level);
    tk(10);
    chk("level", current_level, ecur);
  endtask : hold

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    acc(1'b0, ADDR_HOLD_DELAY, 16'h0000);
    chk("default", reg_rdata, HOLD_DELAY_RST);
    limit();
    for (int t = 1; t < 5; t++)
      home(ADDR_HOME_SWITCH, t[15:0]);
    home(ADDR_HOME_INDEX, 16'h0001);
    home(16'h0000, 16'h0003);
    badtype();
    noenc();
    hold(16'h0002, 16'h0003, 8'h05, 8'h05, 20);
    chk("reduced", current_reduced, 1'b1);
    hold(16'h0002, 16'h0000, 8'h05, 8'h05, 8);
    hold(16'h0000, 16'h0000, 8'h05, 8'h40, 0);
    hold(16'h0001, 16'h0001, 8'h00, 8'h40, 8);
    freeze();
    results();
  end
endmodule : hmhc_top_bench

`default_nettype wire
